// ### rtl/imb_regs.svh
// Constants for the two-wire master: encodings, field positions, counts
`ifndef IMB_REGS_SVH
`define IMB_REGS_SVH

// Port-mode select value that means two-wire master
`define IMB_MODE_MASTER 4'h8
// Width of the baud reload field of the address/baud register
`define IMB_RELOAD_W 7
// Bit positions of the five command bits of control_reg_two
`define IMB_CMD_START 0
`define IMB_CMD_RESTART 1
`define IMB_CMD_STOP 2
`define IMB_CMD_RECV 3
`define IMB_CMD_ACKSEQ 4
// Bit counts of a byte slot
`define IMB_LAST_DATA_BIT 4'h7
`define IMB_ACK_SLOT 4'h8
// Reset values
`define IMB_PIN_IDLE 2'h3
`define IMB_STAT_RST 20'h00000

`endif

// ### rtl/imb_pkg.sv
// Types shared by the two-wire master and its helpers
`include "imb_regs.svh"
package imb_pkg;

	// Sequencer states
	typedef enum logic [4:0] {
		IMB_IDLE, IMB_START_CHK, IMB_START_HOLD, IMB_RS_LOW, IMB_RS_SDA, IMB_RS_SCLWAIT,
		IMB_BIT_LOW, IMB_BIT_WAIT, IMB_BIT_HIGH, IMB_ACK_LOW, IMB_ACK_WAIT, IMB_ACK_HIGH,
		IMB_STOP_LOW, IMB_STOP_WAIT, IMB_STOP_HIGH
	} imb_fsm_t;

	// Software-side control inputs
	typedef struct packed {
		logic [3:0] port_mode_select;
		logic port_enable_bit;
		logic [`IMB_RELOAD_W-1:0] baud_reload;
		logic buf_wr;
		logic [7:0] buf_wdata;
		logic buf_rd;
		logic cmd_wr;
		logic [4:0] cmd_wdata;
		logic ack_value_bit;
		logic irq_clr;
		logic write_collision_flag_clr;
		logic bcol_clr;
	} imb_ctrl_t;

	// Software-side status outputs
	typedef struct packed {
		logic [4:0] cmd;
		logic slave_ack_result;
		logic start_det;
		logic stop_det;
		logic buffer_full_flag;
		logic port_irq_flag;
		logic write_collision_flag;
		logic bus_collision_flag;
		logic [7:0] transfer_buffer;
	} imb_stat_t;

	// Whole state of the master sequencer
	typedef struct packed {
		imb_fsm_t fsm;
		imb_stat_t st;
		logic [7:0] shift_register;
		logic [3:0] bitn;
		logic rx;
		logic scl_low;
		logic sda_low;
		logic req_tgl;
		logic waiting;
		logic [`IMB_RELOAD_W-1:0] reload;
	} imb_main_t;

	// State of the synchroniser
	typedef struct packed {
		logic [2:0] ff;
		logic lvl;
	} imb_sync1_t;

endpackage

// ### rtl/imb_sync.sv
// Three-stage synchroniser with agreement filter and change pulse
`timescale 1ns/100ps
module imb_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	// Clock and reset of the receiving domain
	input wire logic clk_i,
	input wire logic rst_i,
	// Foreign level in, filtered level and change pulse out
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] lvl_o,
	output logic [W-1:0] chg_o
);
	if (W < 1) begin : g_chk
		$error("imb_sync: width must be at least one");
	end

	// One bit per lane; the first stage feeds only the second
	for (genvar i = 0; i < W; i++) begin : g_lane
		imb_pkg::imb_sync1_t s, n;
		always_comb begin
			n = s;
			n.ff = {s.ff[1:0], d_i[i]};
			// A change counts only once stages two and three agree
			if (s.ff[1] == s.ff[2]) begin
				n.lvl = s.ff[2];
			end
		end
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				s <= {{3{RST[i]}}, RST[i]};
			end else begin
				s <= n;
			end
		end
		assign lvl_o[i] = s.lvl;
		assign chg_o[i] = (s.ff[1] == s.ff[2]) && (s.ff[2] != s.lvl);
	end
endmodule

// ### rtl/imb_baud.sv
// Baud tick counter on the half-cycle phase clock
`timescale 1ns/100ps
module imb_baud #(
	parameter int W = 7
) (
	// Phase clock, two ticks per instruction cycle
	input wire logic qclk_i,
	// Reset from the main domain, crossed inside
	input wire logic sys_rst_i,
	// Reload handshake from the main domain
	input wire logic req_tgl_i,
	input wire logic [W-1:0] reload_i,
	output logic done_tgl_o
);
	if (W < 1 || W > 16) begin : g_chk
		$error("imb_baud: reload width must be 1 to 16");
	end

	typedef struct packed {
		logic [W-1:0] cnt;
		logic run;
		logic done_tgl;
	} imb_baud_st_t;

	logic q_rst;
	logic req_ev;
	imb_baud_st_t s, n;

	// Reset and reload toggle brought into the phase domain
	imb_sync #(.W(1), .RST(1'b0)) u_rst (
		.clk_i(qclk_i), .rst_i(1'b0), .d_i(sys_rst_i), .lvl_o(q_rst), .chg_o()
	);
	imb_sync #(.W(1), .RST(1'b0)) u_req (
		.clk_i(qclk_i), .rst_i(q_rst), .d_i(req_tgl_i), .lvl_o(), .chg_o(req_ev)
	);

	// Count down to zero, then stop until the next reload
	always_comb begin
		n = s;
		// Reload word is held steady by the sender until the toggle lands
		if (req_ev) begin
			n.cnt = reload_i;
			n.run = 1'b1;
		end else if (s.run) begin
			if (s.cnt == '0) begin
				n.run = 1'b0;
				n.done_tgl = ~s.done_tgl;
			end else begin
				n.cnt = s.cnt - 1'b1;
			end
		end
	end

	always_ff @(posedge qclk_i) begin
		if (q_rst) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign done_tgl_o = s.done_tgl;
endmodule

// ### rtl/imb_master.sv
// Two-wire master sequencer: START, repeated START, bytes, acknowledge, STOP
//
// Summary of operation
// - Master only with master mode and enable
// - Start/stop flags cleared on reset, disable
// - No queueing; early buffer write sets collision
// - Interrupt flag on every completed bus event
// - Transmit: address, write bit, acked bytes
// - Receive: address with read bit, master acks
// - Transfer ends by STOP or repeated START
// - Buffer write shifts eight bits onto SDA
// - Ninth clock samples slave ack, sets interrupt
// - STOP request; interrupt after STOP finishes
// - Reload from seven-bit field; buffer write starts
// - Counter counts down twice per cycle, stops
// - One SCL period spans two rollovers
// - Finished operation stops clock, SCL holds
// - Released SCL waits sampled high, then reloads
// - START: both high at timeout, SDA low
// - Second period, clear request, keep SDA low
// - Low lines during START: collision, abort
// - Buffer writes during START rejected, collision flag
// - Command bits ignored until START completes
// - Repeated START only from idle
// - Receive one byte, buffer full, interrupt
// - Acknowledge sequence drives ack value one clock
`timescale 1ns/100ps
`include "imb_regs.svh"
module imb_master (
	// Main clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Baud phase clock
	input wire logic qclk_i,
	// Software side
	input wire imb_pkg::imb_ctrl_t ctrl_i,
	output imb_pkg::imb_stat_t stat_o,
	// Open-drain bus pins
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_o,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o
);
	localparam imb_pkg::imb_main_t RST_STATE = '{
		fsm: imb_pkg::IMB_IDLE, st: `IMB_STAT_RST, default: '0
	};

	imb_pkg::imb_main_t s, n;
	logic [1:0] pin_lvl;
	logic scl_hi;
	logic sda_hi;
	logic done_tgl;
	logic done_ev;
	logic tick;
	logic enabled;

	// Request one baud period; the counter must be idle before this
	function automatic imb_pkg::imb_main_t kick(imb_pkg::imb_main_t x,
			logic [`IMB_RELOAD_W-1:0] v);
		kick = x;
		kick.req_tgl = ~x.req_tgl;
		kick.waiting = 1'b1;
		kick.reload = v;
	endfunction

	// Drop back to idle with both lines released
	function automatic imb_pkg::imb_main_t abort_idle(imb_pkg::imb_main_t x);
		abort_idle = x;
		abort_idle.fsm = imb_pkg::IMB_IDLE;
		abort_idle.scl_low = 1'b0;
		abort_idle.sda_low = 1'b0;
		abort_idle.st.cmd = '0;
		abort_idle.st.bus_collision_flag = 1'b1;
	endfunction

	// Bus pins sampled through three flops
	imb_sync #(.W(2), .RST(`IMB_PIN_IDLE)) u_pins (
		.clk_i(clk_i), .rst_i(sys_rst_i), .d_i({scl_i, sda_i}), .lvl_o(pin_lvl), .chg_o()
	);

	// baud counter in the phase domain
	imb_baud #(.W(`IMB_RELOAD_W)) u_baud (
		.qclk_i(qclk_i), .sys_rst_i(sys_rst_i), .req_tgl_i(s.req_tgl),
		.reload_i(s.reload), .done_tgl_o(done_tgl)
	);

	// Timeout toggle back into the main domain
	imb_sync #(.W(1), .RST(1'b0)) u_done (
		.clk_i(clk_i), .rst_i(sys_rst_i), .d_i(done_tgl), .lvl_o(), .chg_o(done_ev)
	);

	assign scl_hi = pin_lvl[1];
	assign sda_hi = pin_lvl[0];
	// master mode needs both mode and enable
	assign enabled = ctrl_i.port_enable_bit
		&& (ctrl_i.port_mode_select == `IMB_MODE_MASTER);
	// A timeout only counts if this side asked for it
	assign tick = done_ev && s.waiting;

	// Next-state logic of the sequencer
	always_comb begin
		n = s;
		// Clears first, so a same-cycle set below wins
		if (ctrl_i.irq_clr) begin
			n.st.port_irq_flag = 1'b0;
		end
		if (ctrl_i.write_collision_flag_clr) begin
			n.st.write_collision_flag = 1'b0;
		end
		if (ctrl_i.bcol_clr) begin
			n.st.bus_collision_flag = 1'b0;
		end
		if (ctrl_i.buf_rd && s.rx) begin
			n.st.buffer_full_flag = 1'b0;
		end
		if (done_ev) begin
			n.waiting = 1'b0;
		end
		// any buffer write outside idle is refused
		if (ctrl_i.buf_wr && (s.fsm != imb_pkg::IMB_IDLE || s.waiting)) begin
			n.st.write_collision_flag = 1'b1;
		end
		case (s.fsm)
			imb_pkg::IMB_IDLE: begin
				if (ctrl_i.buf_wr && !s.waiting) begin
					n = kick(n, ctrl_i.baud_reload);
					n.shift_register = ctrl_i.buf_wdata;
					n.st.buffer_full_flag = 1'b1;
					n.rx = 1'b0;
					n.bitn = '0;
					n.scl_low = 1'b1;
					n.fsm = imb_pkg::IMB_BIT_LOW;
				end else if (ctrl_i.cmd_wr && !s.waiting) begin
					n.st.cmd = '0;
					if (ctrl_i.cmd_wdata[`IMB_CMD_START]) begin
						n.st.cmd[`IMB_CMD_START] = 1'b1;
						if (!scl_hi || !sda_hi) begin
							n = abort_idle(n);
						end else begin
							n = kick(n, ctrl_i.baud_reload);
							n.fsm = imb_pkg::IMB_START_CHK;
						end
					end else if (ctrl_i.cmd_wdata[`IMB_CMD_RESTART]) begin
						n.st.cmd[`IMB_CMD_RESTART] = 1'b1;
						n.scl_low = 1'b1;
						n.sda_low = 1'b0;
						n.fsm = imb_pkg::IMB_RS_LOW;
					end else if (ctrl_i.cmd_wdata[`IMB_CMD_STOP]) begin
						n.st.cmd[`IMB_CMD_STOP] = 1'b1;
						n = kick(n, ctrl_i.baud_reload);
						n.scl_low = 1'b1;
						n.sda_low = 1'b1;
						n.fsm = imb_pkg::IMB_STOP_LOW;
					end else if (ctrl_i.cmd_wdata[`IMB_CMD_RECV]) begin
						// clock in one byte with SDA released
						n.st.cmd[`IMB_CMD_RECV] = 1'b1;
						n = kick(n, ctrl_i.baud_reload);
						n.rx = 1'b1;
						n.bitn = '0;
						n.scl_low = 1'b1;
						n.sda_low = 1'b0;
						n.fsm = imb_pkg::IMB_BIT_LOW;
					end else if (ctrl_i.cmd_wdata[`IMB_CMD_ACKSEQ]) begin
						n.st.cmd[`IMB_CMD_ACKSEQ] = 1'b1;
						n = kick(n, ctrl_i.baud_reload);
						n.scl_low = 1'b1;
						n.sda_low = ~ctrl_i.ack_value_bit;
						n.fsm = imb_pkg::IMB_ACK_LOW;
					end
				end
			end
			imb_pkg::IMB_START_CHK: begin
				// SCL pulled low by someone else
				if (!scl_hi) begin
					n = abort_idle(n);
				end else if (tick) begin
					if (sda_hi) begin
						n = kick(n, ctrl_i.baud_reload);
						n.sda_low = 1'b1;
						n.st.start_det = 1'b1;
						n.st.stop_det = 1'b0;
						n.fsm = imb_pkg::IMB_START_HOLD;
					end else begin
						n = abort_idle(n);
					end
				end
			end
			imb_pkg::IMB_START_HOLD: begin
				if (tick) begin
					n.st.cmd = '0;
					n.st.port_irq_flag = 1'b1;
					n.fsm = imb_pkg::IMB_IDLE;
				end
			end
			imb_pkg::IMB_RS_LOW: begin
				// Period starts only once SCL is seen low
				if (!scl_hi && !s.waiting) begin
					n = kick(n, ctrl_i.baud_reload);
					n.fsm = imb_pkg::IMB_RS_SDA;
				end
			end
			imb_pkg::IMB_RS_SDA: begin
				if (tick) begin
					if (sda_hi) begin
						n.scl_low = 1'b0;
						n.fsm = imb_pkg::IMB_RS_SCLWAIT;
					end else begin
						n = abort_idle(n);
					end
				end
			end
			imb_pkg::IMB_RS_SCLWAIT: begin
				// wait for SCL really high, then reload
				if (scl_hi && !s.waiting) begin
					n = kick(n, ctrl_i.baud_reload);
					n.fsm = imb_pkg::IMB_START_CHK;
				end
			end
			imb_pkg::IMB_BIT_LOW, imb_pkg::IMB_ACK_LOW, imb_pkg::IMB_STOP_LOW: begin
				// bit driven after SCL falls; a same-edge change could fake a START
				if (s.fsm == imb_pkg::IMB_BIT_LOW && !s.rx) begin
					n.sda_low = (s.bitn != `IMB_ACK_SLOT) && !s.shift_register[7];
				end
				// low half of the SCL period ends
				if (tick) begin
					n.scl_low = 1'b0;
					n.fsm = (s.fsm == imb_pkg::IMB_BIT_LOW) ? imb_pkg::IMB_BIT_WAIT :
						(s.fsm == imb_pkg::IMB_ACK_LOW) ? imb_pkg::IMB_ACK_WAIT :
						imb_pkg::IMB_STOP_WAIT;
				end
			end
			imb_pkg::IMB_BIT_WAIT, imb_pkg::IMB_ACK_WAIT, imb_pkg::IMB_STOP_WAIT: begin
				if (scl_hi && !s.waiting) begin
					n = kick(n, ctrl_i.baud_reload);
					n.fsm = (s.fsm == imb_pkg::IMB_BIT_WAIT) ? imb_pkg::IMB_BIT_HIGH :
						(s.fsm == imb_pkg::IMB_ACK_WAIT) ? imb_pkg::IMB_ACK_HIGH :
						imb_pkg::IMB_STOP_HIGH;
				end
			end
			imb_pkg::IMB_BIT_HIGH: begin
				if (tick) begin
					n.scl_low = 1'b1;
					n.bitn = s.bitn + 4'h1;
					if (s.rx) begin
						n.shift_register = {s.shift_register[6:0], sda_hi};
						if (s.bitn == `IMB_LAST_DATA_BIT) begin
							// byte to buffer, flags up, SCL held low
							n.st.transfer_buffer = {s.shift_register[6:0], sda_hi};
							n.st.buffer_full_flag = 1'b1;
							n.st.port_irq_flag = 1'b1;
							n.st.cmd = '0;
							n.fsm = imb_pkg::IMB_IDLE;
						end else begin
							n = kick(n, ctrl_i.baud_reload);
							n.fsm = imb_pkg::IMB_BIT_LOW;
						end
					end else if (s.bitn == `IMB_ACK_SLOT) begin
						// ack sampled at the ninth falling edge
						n.st.slave_ack_result = sda_hi;
						n.st.port_irq_flag = 1'b1;
						n.fsm = imb_pkg::IMB_IDLE;
					end else begin
						// Next bit up, MSB first; buffer empty after eight
						n.shift_register = {s.shift_register[6:0], 1'b0};
						if (s.bitn == `IMB_LAST_DATA_BIT) begin
							n.st.buffer_full_flag = 1'b0;
						end
						n = kick(n, ctrl_i.baud_reload);
						n.fsm = imb_pkg::IMB_BIT_LOW;
					end
				end
			end
			imb_pkg::IMB_ACK_HIGH: begin
				// pull SCL low, auto-clear, back to idle
				if (tick) begin
					n.scl_low = 1'b1;
					n.st.cmd = '0;
					n.st.port_irq_flag = 1'b1;
					n.fsm = imb_pkg::IMB_IDLE;
				end
			end
			imb_pkg::IMB_STOP_HIGH: begin
				// SDA rises with SCL high, then interrupt
				if (tick) begin
					n.sda_low = 1'b0;
					n.st.stop_det = 1'b1;
					n.st.start_det = 1'b0;
					n.st.cmd = '0;
					n.st.port_irq_flag = 1'b1;
					n.fsm = imb_pkg::IMB_IDLE;
				end
			end
			default: begin
				n = abort_idle(n);
			end
		endcase
		// disabled port forgets bus conditions and lets go
		if (!enabled) begin
			n.fsm = imb_pkg::IMB_IDLE;
			n.st.start_det = 1'b0;
			n.st.stop_det = 1'b0;
			n.st.cmd = '0;
			n.scl_low = 1'b0;
			n.sda_low = 1'b0;
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			s <= RST_STATE;
		end else begin
			s <= n;
		end
	end

	// Open-drain drive: low only, enable while pulling
	assign stat_o = s.st;
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe_o = s.scl_low;
	assign sda_oe_o = s.sda_low;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence start_fire_s;
		s.fsm == imb_pkg::IMB_START_CHK && tick && scl_hi && sda_hi && enabled;
	endsequence
	sequence start_done_s;
		s.fsm == imb_pkg::IMB_START_HOLD && tick && enabled;
	endsequence

	buf_write_refused_a: assert property (
		ctrl_i.buf_wr && s.fsm != imb_pkg::IMB_IDLE && enabled && !tick
		|=> s.st.write_collision_flag && s.shift_register == $past(s.shift_register))
		else $error("buffer write during operation not refused");
	cmd_lockout_a: assert property (
		s.fsm == imb_pkg::IMB_START_CHK && scl_hi && !tick && enabled && ctrl_i.cmd_wr
		|=> s.st.cmd == $past(s.st.cmd))
		else $error("command bits changed during START");
	disable_clears_a: assert property (
		!enabled |=> !s.st.start_det && !s.st.stop_det && !scl_oe_o && !sda_oe_o)
		else $error("disabled port kept flags or drive");
	start_sequence_a: assert property (
		start_fire_s |=> sda_oe_o && scl_oe_o == 1'b0 && s.st.start_det)
		else $error("START did not pull SDA low with flag");
	start_complete_a: assert property (
		start_done_s |=> s.st.cmd == '0 && sda_oe_o && s.st.port_irq_flag)
		else $error("START completion wrong");
	start_collision_a: assert property (
		s.fsm == imb_pkg::IMB_START_CHK && !scl_hi && enabled
		|=> s.st.bus_collision_flag && s.fsm == imb_pkg::IMB_IDLE && !sda_oe_o)
		else $error("collision during START not handled");
	stretch_hold_a: assert property (
		s.fsm == imb_pkg::IMB_BIT_WAIT && !scl_hi |=> $stable(s.req_tgl))
		else $error("counter reloaded while SCL held low");
	ack_sample_a: assert property (
		s.fsm == imb_pkg::IMB_BIT_HIGH && !s.rx && s.bitn == `IMB_ACK_SLOT && tick && enabled
		|=> s.st.slave_ack_result == $past(sda_hi) && s.st.port_irq_flag && scl_oe_o)
		else $error("slave acknowledge not captured");
	stop_irq_a: assert property (
		s.fsm == imb_pkg::IMB_STOP_HIGH && !tick |=> !s.st.stop_det || $past(s.st.stop_det))
		else $error("STOP flagged before it finished");
	rx_byte_a: assert property (
		s.fsm == imb_pkg::IMB_BIT_HIGH && s.rx && s.bitn == `IMB_LAST_DATA_BIT && tick && enabled
		|=> s.st.buffer_full_flag && s.st.port_irq_flag && s.fsm == imb_pkg::IMB_IDLE)
		else $error("received byte not delivered");
endmodule

// ### tb/imb_slave_model.sv
// Behavioural two-wire slave that faces the master across the bus
`timescale 1ns/100ps
module imb_slave_model #(
	parameter logic [6:0] ADDR = 7'h2A,
	parameter logic [7:0] RDATA = 8'h3C
) (
	// Wire levels seen on the bus
	input wire logic scl_i,
	input wire logic sda_i,
	// Test controls: slow answers, bus held by a stranger
	input wire logic stretch_i,
	input wire logic hold_i,
	// Pull-down enables, high while pulling low
	output logic scl_oe_o,
	output logic sda_oe_o,
	// Observations for the bench
	output logic [7:0] rx_o,
	output logic mack_o,
	output logic [7:0] starts_o
);
	logic [7:0] sh;
	logic [3:0] cnt;
	logic addr_ph;
	logic sel;
	logic rd;
	logic sending;
	logic drv;
	logic hold_scl;

	// Quiet state at time zero
	initial begin
		{sh, cnt, sel, rd, sending, drv, hold_scl, rx_o, mack_o, starts_o} = '0;
		addr_ph = 1'b1;
	end

	// Both lines pulled low together fake a bus owned by someone else
	assign scl_oe_o = hold_scl | hold_i;
	assign sda_oe_o = drv | hold_i;

	// Falling SDA with SCL high opens a new address slot
	always @(negedge sda_i) begin
		if (scl_i === 1'b1) begin
			starts_o = starts_o + 8'h01;
			{cnt, sel, rd, sending, drv} = '0;
			addr_ph = 1'b1;
		end
	end

	// Bits and the master's acknowledge are taken while SCL is high
	always @(posedge scl_i) begin
		if (cnt < 4'h8)
			sh = {sh[6:0], sda_i};
		else
			mack_o = sda_i;
		cnt = cnt + 4'h1;
	end

	// ack address and written bytes, send read bytes
	always @(negedge scl_i) begin
		if (cnt == 4'h8) begin
			if (addr_ph) begin
				sel = (sh[7:1] == ADDR);
				rd = sh[0];
			end else if (sel && !rd) begin
				rx_o = sh;
			end
			drv = sel && (addr_ph || !rd);
		end else if (cnt == 4'h9) begin
			cnt = 4'h0;
			sending = sel && rd && (addr_ph || !mack_o);
			addr_ph = 1'b0;
			drv = sending && !RDATA[7];
		end else begin
			drv = sending && (cnt < 4'h8) && !RDATA[3'h7 - cnt[2:0]];
		end
	end

	// Slow partner keeps SCL low a while after each fall
	always @(negedge scl_i) begin
		if (stretch_i) begin
			hold_scl = 1'b1;
			#300;
			hold_scl = 1'b0;
		end
	end
endmodule

// ### tb/i2c_master_start_brg_tb_top.sv
// Self-checking bench for the two-wire master sequencer
`timescale 1ns/100ps
`include "imb_regs.svh"
module i2c_master_start_brg_tb_top;
	localparam logic [6:0] ADDR = 7'h2A;
	localparam logic [7:0] RDATA = 8'h3C;
	localparam logic [6:0] RELOAD = 7'h03;
	localparam realtime BAUD_PERIOD_NS = (RELOAD + 1) * 64.0;
	localparam logic [4:0] C_START = 5'h01 << `IMB_CMD_START;
	localparam logic [4:0] C_RS = 5'h01 << `IMB_CMD_RESTART;
	localparam logic [4:0] C_STOP = 5'h01 << `IMB_CMD_STOP;
	localparam logic [4:0] C_RECV = 5'h01 << `IMB_CMD_RECV;
	localparam logic [4:0] C_ACK = 5'h01 << `IMB_CMD_ACKSEQ;
	logic clk_i, qclk, sys_rst_i, scl_oe, sda_oe, s_scl_oe, s_sda_oe, scl_w, sda_w;
	logic stretch, hold, mack, scl_lo, sda_lo;
	logic [7:0] rx, starts, st0;
	imb_pkg::imb_ctrl_t ctrl;
	imb_pkg::imb_stat_t stat;
	int n_fail, total_checks, cyc;
	realtime t_up, min_hi;

	// Open-drain wires with pull-ups
	assign scl_w = !(scl_oe | s_scl_oe);
	assign sda_w = !(sda_oe | s_sda_oe);

	imb_master dut (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .qclk_i(qclk), .ctrl_i(ctrl), .stat_o(stat),
		.scl_i(scl_w), .scl_o(scl_lo), .scl_oe_o(scl_oe),
		.sda_i(sda_w), .sda_o(sda_lo), .sda_oe_o(sda_oe)
	);
	imb_slave_model #(.ADDR(ADDR), .RDATA(RDATA)) slave (
		.scl_i(scl_w), .sda_i(sda_w), .stretch_i(stretch), .hold_i(hold),
		.scl_oe_o(s_scl_oe), .sda_oe_o(s_sda_oe), .rx_o(rx), .mack_o(mack), .starts_o(starts)
	);

	// Main clock and unrelated baud phase clock
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	initial begin
		qclk = 1'b0;
		#13;
		forever #32 qclk = ~qclk;
	end

	// Shortest SCL high phase seen on the wire
	always @(posedge scl_w) t_up = $realtime;
	always @(negedge scl_w) if ($realtime - t_up < min_hi) min_hi = $realtime - t_up;

	// Hang guard: a run well past its expected length fails
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 30000) begin
			n_fail++;
			$display("MISMATCH timeout expected done seen hung");
			final_report();
		end
	end

	task automatic final_report();
		$display("Checks made %0d, mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cmd(input logic [4:0] c);
		@(posedge clk_i);
		ctrl.cmd_wdata <= c;
		ctrl.cmd_wr <= 1'b1;
		@(posedge clk_i);
		ctrl.cmd_wr <= 1'b0;
	endtask

	task automatic wbuf(input logic [7:0] d);
		@(posedge clk_i);
		ctrl.buf_wdata <= d;
		ctrl.buf_wr <= 1'b1;
		@(posedge clk_i);
		ctrl.buf_wr <= 1'b0;
	endtask

	// Clear pulses: irq, write collision, bus collision
	task automatic pulse_clr(input logic [2:0] m);
		@(posedge clk_i);
		{ctrl.irq_clr, ctrl.write_collision_flag_clr, ctrl.bcol_clr} <= m;
		@(posedge clk_i);
		{ctrl.irq_clr, ctrl.write_collision_flag_clr, ctrl.bcol_clr} <= 3'h0;
	endtask

	// Bounded wait for the interrupt flag, which must stay until cleared
	task automatic wait_irq();
		int n;
		n = 0;
		@(negedge clk_i);
		while (stat.port_irq_flag !== 1'b1 && n < 4000) begin
			@(negedge clk_i);
			n++;
		end
		repeat (3) @(negedge clk_i);
		chk("irq", 24'h1, {23'h0, stat.port_irq_flag});
		pulse_clr(3'h4);
		@(negedge clk_i);
		chk("irq_clear", 24'h0, {23'h0, stat.port_irq_flag});
	endtask

	task automatic t_mode();
		@(posedge clk_i);
		ctrl.port_enable_bit <= 1'b1;
		cmd(C_START);
		repeat (100) @(negedge clk_i);
		chk("oe", 24'h0, {22'h0, scl_oe, sda_oe});
		chk("start_det", 24'h0, {23'h0, stat.start_det});
		@(posedge clk_i);
		ctrl.port_enable_bit <= 1'b0;
		repeat (3) @(posedge clk_i);
		ctrl.port_mode_select <= `IMB_MODE_MASTER;
		ctrl.port_enable_bit <= 1'b1;
		repeat (3) @(posedge clk_i);
		$display("test mode done");
	endtask

	task automatic t_start();
		st0 = starts;
		cmd(C_START);
		wbuf(8'h55);
		cmd(C_STOP);
		@(negedge clk_i);
		chk("write_collision_flag", 24'h1, {23'h0, stat.write_collision_flag});
		wait_irq();
		chk("flags", 24'h2, {22'h0, stat.start_det, stat.stop_det});
		chk("cmd", 24'h0, {19'h0, stat.cmd});
		chk("bus", 24'h2, {22'h0, scl_w, sda_w});
		chk("starts", {16'h0, st0 + 8'h01}, {16'h0, starts});
		chk("buffer", 24'h0, {16'h0, stat.transfer_buffer});
		pulse_clr(3'h2);
		$display("test start done");
	endtask

	task automatic t_write();
		min_hi = 1.0e9;
		stretch <= 1'b1;
		wbuf({ADDR, 1'b0});
		@(negedge clk_i);
		chk("bf", 24'h1, {23'h0, stat.buffer_full_flag});
		wbuf(8'hFF);
		cmd(C_STOP);
		wait_irq();
		chk("ack", 24'h0, {23'h0, stat.slave_ack_result});
		chk("write_collision_flag", 24'h1, {23'h0, stat.write_collision_flag});
		chk("stop_det", 24'h0, {23'h0, stat.stop_det});
		pulse_clr(3'h2);
		wbuf(8'hA5);
		wait_irq();
		chk("rx", 24'hA5, {16'h0, rx});
		chk("bf", 24'h0, {23'h0, stat.buffer_full_flag});
		repeat (20) @(negedge clk_i);
		chk("scl_held", 24'h0, {23'h0, scl_w});
		chk("high_time", 24'h1, {23'h0, min_hi >= BAUD_PERIOD_NS});
		stretch <= 1'b0;
		$display("test write done");
	endtask

	task automatic t_stop();
		cmd(C_STOP);
		wait_irq();
		chk("flags", 24'h1, {22'h0, stat.start_det, stat.stop_det});
		chk("bus", 24'h3, {22'h0, scl_w, sda_w});
		$display("test stop done");
	endtask

	task automatic t_read();
		st0 = starts;
		cmd(C_START);
		wait_irq();
		wbuf({7'h11, 1'b0});
		wait_irq();
		chk("nack", 24'h1, {23'h0, stat.slave_ack_result});
		cmd(C_RS);
		wait_irq();
		chk("starts", {16'h0, st0 + 8'h02}, {16'h0, starts});
		chk("start_det", 24'h1, {23'h0, stat.start_det});
		wbuf({ADDR, 1'b1});
		wait_irq();
		chk("ack", 24'h0, {23'h0, stat.slave_ack_result});
		for (int i = 0; i < 2; i++) begin
			cmd(C_RECV);
			wait_irq();
			chk("rbuf", {16'h0, RDATA}, {16'h0, stat.transfer_buffer});
			chk("bf", 24'h1, {23'h0, stat.buffer_full_flag});
			@(posedge clk_i);
			ctrl.buf_rd <= 1'b1;
			@(posedge clk_i);
			ctrl.buf_rd <= 1'b0;
			ctrl.ack_value_bit <= i[0];
			@(negedge clk_i);
			chk("bf_rd", 24'h0, {23'h0, stat.buffer_full_flag});
			cmd(C_ACK);
			wait_irq();
			chk("mack", {23'h0, i[0]}, {23'h0, mack});
			chk("cmd", 24'h0, {19'h0, stat.cmd});
		end
		cmd(C_STOP);
		wait_irq();
		$display("test read done");
	endtask

	task automatic t_coll();
		int n;
		@(posedge clk_i);
		hold <= 1'b1;
		repeat (10) @(posedge clk_i);
		cmd(C_START);
		n = 0;
		while (stat.bus_collision_flag !== 1'b1 && n < 300) begin
			@(negedge clk_i);
			n++;
		end
		chk("bcol", 24'h1, {23'h0, stat.bus_collision_flag});
		chk("cmd", 24'h0, {19'h0, stat.cmd});
		chk("oe", 24'h0, {22'h0, scl_oe, sda_oe});
		@(posedge clk_i);
		hold <= 1'b0;
		pulse_clr(3'h1);
		@(negedge clk_i);
		chk("bcol_clear", 24'h0, {23'h0, stat.bus_collision_flag});
		// Lines free again, then SCL pulled low inside the first period
		repeat (4) @(posedge clk_i);
		cmd(C_START);
		hold <= 1'b1;
		repeat (6) @(negedge clk_i);
		chk("bcol_run", 24'h1, {23'h0, stat.bus_collision_flag});
		chk("oe_run", 24'h0, {22'h0, scl_oe, sda_oe});
		@(posedge clk_i);
		hold <= 1'b0;
		pulse_clr(3'h1);
		$display("test collision done");
	endtask

	task automatic t_disable();
		repeat (10) @(posedge clk_i);
		cmd(C_START);
		wait_irq();
		@(posedge clk_i);
		ctrl.port_enable_bit <= 1'b0;
		repeat (3) @(negedge clk_i);
		chk("flags", 24'h0, {22'h0, stat.start_det, stat.stop_det});
		chk("oe", 24'h0, {22'h0, scl_oe, sda_oe});
		@(posedge clk_i);
		ctrl.port_enable_bit <= 1'b1;
		$display("test disable done");
	endtask

	// Main sequence; three reset cycles still reach the baud domain
	initial begin
		ctrl = '0;
		ctrl.baud_reload = RELOAD;
		hold = 1'b0;
		stretch = 1'b0;
		n_fail = 0;
		total_checks = 0;
		cyc = 0;
		t_up = 0.0;
		min_hi = 1.0e9;
		sys_rst_i = 1'b1;
		repeat (3) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		@(negedge clk_i);
		chk("stat", 24'h0, {4'h0, stat});
		chk("oe", 24'h0, {20'h0, scl_lo, sda_lo, scl_oe, sda_oe});
		$display("test reset done");
		repeat (10) @(posedge clk_i);
		t_mode();
		t_start();
		t_write();
		t_stop();
		t_read();
		t_coll();
		t_disable();
		final_report();
	end
endmodule
